// ==== design/fiap_pkg.sv ====
// ************************************************************
// Flash in-application programming sequencer constants
// ************************************************************
package fiap_pkg;

	// ************************************************************
	// Register offsets and field positions
	// ************************************************************
	localparam logic [7:0] ADDR_CMD_STATUS = 8'hd5;
	localparam logic [7:0] ADDR_DATA_PORT  = 8'hd6;
	localparam logic [7:0] ADDR_OPTION     = 8'hfc;
	localparam int         IDLE_BIT        = 7;
	localparam int         FAIL_BIT        = 6;
	localparam int         WDT_BIT         = 3;
	localparam int         LOCK_MSB        = 5;
	localparam int         LOCK_LSB        = 3;
	localparam logic [7:0] LOCK_ADDR       = 8'h40;

	// ************************************************************
	// Signature addresses
	// ************************************************************
	localparam logic [7:0] SIG_MFR_ADDR  = 8'h30;
	localparam logic [7:0] SIG_PART_ADDR = 8'h31;
	localparam logic [7:0] SIG_EXT_ADDR  = 8'h60;

	// ************************************************************
	// Reset values and masks
	// ************************************************************
	localparam logic [3:0] CMD_RESET       = 4'h0;
	localparam logic [7:0] ERASED_BYTE     = 8'hff;
	localparam logic [7:0] OPT_UNDEF_MASK  = 8'hf7;
	localparam logic [2:0] LOCK_ERASED     = 3'h7;
	localparam logic [15:0] UPPER_LO       = 16'h2000;
	localparam logic [15:0] UPPER_HI       = 16'h3fff;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS   = 100;
	localparam int IDLE_CLEAR_NS   = 1000;
	localparam int IDLE_CLEAR_CYC  = IDLE_CLEAR_NS / CLK_PERIOD_NS;

	// ************************************************************
	// Command codes
	// ************************************************************
	typedef enum logic [3:0] {
		CMD_READ      = 4'h0,
		CMD_VFY_OPT   = 4'h1,
		CMD_VFY_SEC   = 4'h2,
		CMD_VFY_UPPER = 4'h3,
		CMD_WR_OPT    = 4'h9,
		CMD_WR_SEC    = 4'ha,
		CMD_WR_UPPER  = 4'hb,
		CMD_ER_OPT    = 4'hc,
		CMD_ER_SEC    = 4'hd,
		CMD_ER_UPPER  = 4'he,
		CMD_SYS_RESET = 4'hf
	} fiap_cmd_t;

	typedef enum logic [1:0] {
		SEL_UPPER  = 2'h0,
		SEL_SEC    = 2'h1,
		SEL_OPTION = 2'h2
	} fiap_sel_t;

	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_ERASE   = 2'h2
	} fiap_op_t;

endpackage

// ==== design/fiap_sequencer.sv ====
`timescale 1ns/1ps
module fiap_sequencer #(
	parameter logic [7:0] MFR_ID  = 8'h5a, // Arbitrary value.
	parameter logic [7:0] PART_ID = 8'h11, // Arbitrary value.
	parameter logic [7:0] EXT_ID  = 8'h22  // Arbitrary value.
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Special-function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        ta_open,
	// Flash macro port
	output logic             fl_start,
	output logic             fl_rd,
	output logic      [1:0]  fl_sel,
	output logic      [1:0]  fl_op,
	output logic      [15:0] fl_addr,
	output logic      [7:0]  fl_wdata,
	input  wire logic [7:0]  fl_rdata,
	input  wire logic        fl_done,
	input  wire logic        fl_fail,
	// Loader and signature port
	input  wire logic        ldr_mode_pin,
	input  wire logic        par_mode_pin,
	input  wire logic [7:0]  sig_addr,
	output logic      [7:0]  sig_rdata,
	output logic             ldr_verify_ok,
	output logic             ldr_program_ok,
	// System controls
	output logic             upper_exec_en,
	output logic             wdt_por_en,
	output logic             sys_reset_req
);

	typedef enum logic [1:0] {
		ST_COLLECT,
		ST_BUSY,
		ST_SPENT
	} fiap_state_t;

	// ************************************************************
	// Register bus decode
	// ************************************************************
	fiap_state_t state_reg;
	logic [3:0]  cmd_reg;
	logic        idle_reg;
	logic        fail_reg;
	logic [7:0]  data_reg;
	logic [15:0] addr_reg;
	logic [1:0]  cnt_reg;
	logic [7:0]  option_reg;
	logic [2:0]  lock_reg;
	logic        rd_pend_reg;
	logic        opt_pend_reg;
	logic [1:0]  mode_s1_reg;
	logic [1:0]  mode_s2_reg;
	logic        cmd_wr_ok;
	logic        data_wr;
	logic [1:0]  need;
	logic        last;
	logic [15:0] addr_next;
	logic        is_read;
	logic        in_range;
	logic        loader;
	logic [1:0]  sel_code;

	// Writes without the unlock window, or during an operation, die here.
	assign cmd_wr_ok = sfr_wr && sfr_addr == fiap_pkg::ADDR_CMD_STATUS
		&& ta_open && state_reg != ST_BUSY;
	// The data port is dead in read mode and after a completed operation.
	assign data_wr = sfr_wr && sfr_addr == fiap_pkg::ADDR_DATA_PORT
		&& cmd_reg != fiap_pkg::CMD_READ
		&& state_reg == ST_COLLECT;

	always_comb begin
		case (cmd_reg)
			fiap_pkg::CMD_VFY_SEC:   need = 2'h1;
			fiap_pkg::CMD_VFY_UPPER: need = 2'h2;
			fiap_pkg::CMD_WR_OPT:    need = 2'h1;
			fiap_pkg::CMD_WR_SEC:    need = 2'h2;
			fiap_pkg::CMD_WR_UPPER:  need = 2'h3;
			fiap_pkg::CMD_ER_OPT:    need = 2'h1;
			fiap_pkg::CMD_ER_SEC:    need = 2'h1;
			fiap_pkg::CMD_ER_UPPER:  need = 2'h1;
			default:                 need = 2'h0;
		endcase
	end

	assign last      = data_wr && need != 2'h0 && cnt_reg + 2'h1 == need;
	assign addr_next = {addr_reg[7:0], sfr_wdata};
	assign is_read   = cmd_reg == fiap_pkg::CMD_VFY_SEC
		|| cmd_reg == fiap_pkg::CMD_VFY_UPPER;
	// Erase codes sit one step below their write twins, so shift them up.
	assign sel_code  = cmd_reg[1:0] + {1'b0, &cmd_reg[3:2]};
	// Upper-bank accesses outside the bank fail instead of reaching flash.
	assign in_range  = cmd_reg == fiap_pkg::CMD_VFY_UPPER
		? (addr_next >= fiap_pkg::UPPER_LO
			&& addr_next <= fiap_pkg::UPPER_HI)
		: cmd_reg == fiap_pkg::CMD_WR_UPPER
		? (addr_reg >= fiap_pkg::UPPER_LO
			&& addr_reg <= fiap_pkg::UPPER_HI)
		: 1'b1;

	// ************************************************************
	// Command field
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_reg <= fiap_pkg::CMD_RESET;
		end else if (cmd_wr_ok) begin
			cmd_reg <= sfr_wdata[3:0];
		end else if (cmd_reg == fiap_pkg::CMD_SYS_RESET) begin
			cmd_reg <= fiap_pkg::CMD_RESET;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= cmd_wr_ok
				&& sfr_wdata[3:0] == fiap_pkg::CMD_SYS_RESET;
		end
	end

	assign upper_exec_en = cmd_reg == fiap_pkg::CMD_READ;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_COLLECT;
			idle_reg  <= 1'b1;
			fail_reg  <= 1'b0;
			cnt_reg   <= 2'h0;
			addr_reg  <= 16'h0000;
			fl_start  <= 1'b0;
			fl_rd     <= 1'b0;
			fl_sel    <= fiap_pkg::SEL_UPPER;
			fl_op     <= fiap_pkg::OP_READ;
			fl_addr   <= 16'h0000;
			fl_wdata  <= 8'h00;
		end else begin
			fl_start <= 1'b0;
			fl_rd    <= 1'b0;
			if (cmd_wr_ok) begin
				state_reg <= ST_COLLECT;
				cnt_reg   <= 2'h0;
				fail_reg  <= 1'b0;
			end else if (data_wr) begin
				cnt_reg  <= cnt_reg + 2'h1;
				addr_reg <= addr_next;
				if (last) begin
					state_reg <= ST_SPENT;
					fl_wdata  <= sfr_wdata;
					fl_sel    <= sel_code == 2'h1 ? fiap_pkg::SEL_OPTION
						: sel_code == 2'h2 ? fiap_pkg::SEL_SEC
						: fiap_pkg::SEL_UPPER;
					fl_op     <= is_read ? fiap_pkg::OP_READ
						: cmd_reg[3:2] == 2'h3 ? fiap_pkg::OP_ERASE
						: fiap_pkg::OP_PROGRAM;
					fl_addr   <= is_read ? addr_next : addr_reg;
					if (!in_range) begin
						fail_reg <= 1'b1;
					end else if (is_read) begin
						fl_rd <= 1'b1;
					end else begin
						state_reg <= ST_BUSY;
						fl_start  <= 1'b1;
						idle_reg  <= 1'b0;
					end
				end
			end else if (state_reg == ST_BUSY && (fl_done || fl_fail)) begin
				state_reg <= ST_SPENT;
				idle_reg  <= 1'b1;
				fail_reg  <= fl_fail;
			end
		end
	end

	// ************************************************************
	// Data port, option byte and lock shadow
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_reg     <= 8'h00;
			rd_pend_reg  <= 1'b0;
			opt_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg  <= fl_rd;
			opt_pend_reg <= cmd_wr_ok
				&& sfr_wdata[3:0] == fiap_pkg::CMD_VFY_OPT;
			if (opt_pend_reg) begin
				data_reg <= option_reg | fiap_pkg::OPT_UNDEF_MASK;
			end else if (rd_pend_reg) begin
				data_reg <= fl_rdata;
			end else if (data_wr) begin
				// A verify aimed outside the bank answers erased data.
				data_reg <= last && !in_range
					? fiap_pkg::ERASED_BYTE : sfr_wdata;
			end
		end
	end

	// The option byte lives in flash; this shadow follows each
	// successful option operation so the watchdog setting is live.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			option_reg <= fiap_pkg::ERASED_BYTE;
			lock_reg   <= fiap_pkg::LOCK_ERASED;
		end else if (state_reg == ST_BUSY && fl_done && !fl_fail) begin
			if (fl_sel == fiap_pkg::SEL_OPTION) begin
				option_reg <= fl_op == fiap_pkg::OP_ERASE
					? fiap_pkg::ERASED_BYTE : fl_wdata;
			end else if (fl_sel == fiap_pkg::SEL_SEC) begin
				if (fl_op == fiap_pkg::OP_ERASE) begin
					lock_reg <= fiap_pkg::LOCK_ERASED;
				end else if (fl_addr[7:0] == fiap_pkg::LOCK_ADDR) begin
					lock_reg <= lock_reg
						& fl_wdata[fiap_pkg::LOCK_MSB:fiap_pkg::LOCK_LSB];
				end
			end
		end
	end

	assign wdt_por_en = !option_reg[fiap_pkg::WDT_BIT];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == fiap_pkg::ADDR_CMD_STATUS) begin
				sfr_rdata <= {idle_reg, fail_reg, 2'b00, cmd_reg};
			end else if (sfr_addr == fiap_pkg::ADDR_DATA_PORT
				&& cmd_reg != fiap_pkg::CMD_READ) begin
				sfr_rdata <= data_reg;
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// ************************************************************
	// Loader modes
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_s1_reg <= 2'b00;
			mode_s2_reg <= 2'b00;
		end else begin
			mode_s1_reg <= {par_mode_pin, ldr_mode_pin};
			mode_s2_reg <= mode_s1_reg;
		end
	end

	assign loader = |mode_s2_reg;
	// Levels stack: any lock bit stops loading, bits zero or one also stop verify.
	assign ldr_program_ok = loader && &lock_reg;
	assign ldr_verify_ok  = loader && &lock_reg[1:0];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sig_rdata <= 8'h00;
		end else if (!loader) begin
			sig_rdata <= 8'h00;
		end else begin
			case (sig_addr)
				fiap_pkg::SIG_MFR_ADDR:  sig_rdata <= MFR_ID;
				fiap_pkg::SIG_PART_ADDR: sig_rdata <= PART_ID;
				fiap_pkg::SIG_EXT_ADDR:  sig_rdata <= EXT_ID;
				fiap_pkg::ADDR_OPTION:
					sig_rdata <= option_reg | fiap_pkg::OPT_UNDEF_MASK;
				default:                 sig_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	localparam int CLR_CYC = fiap_pkg::IDLE_CLEAR_CYC;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_cmd_needs_unlock: assert property (
		sfr_wr && sfr_addr == fiap_pkg::ADDR_CMD_STATUS && !ta_open
		|=> cmd_reg == $past(cmd_reg) || $past(cmd_reg) == 4'hf)
		else $error("Locked command write changed the field.");
	a_busy_ignores_cmd: assert property (
		state_reg == ST_BUSY |=> $stable(cmd_reg))
		else $error("Command changed during an operation.");
	a_start_clears_idle: assert property (
		last && in_range && !is_read |-> ##[1:CLR_CYC] !idle_reg)
		else $error("Idle flag not cleared after the last byte.");
	a_idle_low_busy: assert property (
		!idle_reg |-> state_reg == ST_BUSY)
		else $error("Idle flag low outside an operation.");
	a_fail_sets_flag: assert property (
		state_reg == ST_BUSY && fl_fail && !cmd_wr_ok
		|=> fail_reg && idle_reg)
		else $error("Failure did not set the error flag.");
	a_exec_gate: assert property (
		cmd_wr_ok && sfr_wdata[3:0] != 4'h0 |=> !upper_exec_en)
		else $error("Upper bank executable outside read mode.");
	a_opt_readback: assert property (
		cmd_wr_ok && sfr_wdata[3:0] == fiap_pkg::CMD_VFY_OPT
		|=> ##1 data_reg == (option_reg | 8'hf7))
		else $error("Option byte not in data port in time.");
	a_sys_reset: assert property (
		cmd_wr_ok && sfr_wdata[3:0] == 4'hf
		|=> sys_reset_req ##1 cmd_reg == 4'h0)
		else $error("System reset command mishandled.");
	a_no_reuse: assert property (
		state_reg == ST_SPENT && !cmd_wr_ok |=> !fl_start && !fl_rd)
		else $error("Operation started without a new command.");
	a_upper_range: assert property (
		fl_start && fl_sel == fiap_pkg::SEL_UPPER
		&& fl_op != fiap_pkg::OP_ERASE
		|-> fl_addr >= 16'h2000 && fl_addr <= 16'h3fff)
		else $error("Access outside the upper bank.");

	c_program_done: cover property (
		fl_start && fl_op == fiap_pkg::OP_PROGRAM ##[1:50] idle_reg);
	c_verify_upper: cover property (fl_rd && fl_sel == fiap_pkg::SEL_UPPER);
	c_fail: cover property (state_reg == ST_BUSY && fl_fail);
	c_sys_reset: cover property (sys_reset_req);

endmodule

// ==== tb/flash_iap_sequencer_bench.sv ====
`timescale 1ns/1ps
module flash_iap_sequencer_bench;
	// ************************************************************
	// Signals
	// ************************************************************
	localparam logic [7:0] T_MFR  = 8'h3c; // Arbitrary value.
	localparam logic [7:0] T_PART = 8'h7e; // Arbitrary value.
	localparam logic [7:0] T_EXT  = 8'h0d; // Arbitrary value.
	localparam logic [7:0] A_CMD  = fiap_pkg::ADDR_CMD_STATUS;
	localparam logic [7:0] A_DAT  = fiap_pkg::ADDR_DATA_PORT;
	logic        sys_clk, rst, sfr_wr, sfr_rd, ta_open;
	logic        fl_start, fl_rd, fl_done, fl_fail;
	logic        ldr_mode_pin, par_mode_pin, ldr_verify_ok, ldr_program_ok;
	logic        upper_exec_en, wdt_por_en, sys_reset_req;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, fl_wdata, fl_rdata;
	logic [7:0]  sig_addr, sig_rdata, rd_val;
	logic [1:0]  fl_sel, fl_op;
	logic [15:0] fl_addr;
	int          err_total;
	int          cmp_count;

	fiap_sequencer #(.MFR_ID(T_MFR), .PART_ID(T_PART), .EXT_ID(T_EXT)) DUT (
		.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .ta_open(ta_open), .fl_start(fl_start),
		.fl_rd(fl_rd), .fl_sel(fl_sel), .fl_op(fl_op), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .fl_done(fl_done),
		.fl_fail(fl_fail), .ldr_mode_pin(ldr_mode_pin),
		.par_mode_pin(par_mode_pin), .sig_addr(sig_addr),
		.sig_rdata(sig_rdata), .ldr_verify_ok(ldr_verify_ok),
		.ldr_program_ok(ldr_program_ok), .upper_exec_en(upper_exec_en),
		.wdt_por_en(wdt_por_en), .sys_reset_req(sys_reset_req)
	);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic give_verdict();
		$display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk16({8'h00, got}, {8'h00, exp});
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk16({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge sys_clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	task automatic chk_read(input logic [7:0] a, input logic [7:0] exp);
		sfr_read(a, rd_val);
		chk8(rd_val, exp);
	endtask

	// The unlock window is opened a cycle early so it covers the write edge.
	task automatic cmd_write(input logic [3:0] c, input logic ta);
		@(negedge sys_clk);
		ta_open = ta;
		sfr_write(A_CMD, {4'h0, c});
		ta_open = 1'b0;
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = fl_start;
			1: pick = fl_rd;
			default: pick = sys_reset_req;
		endcase
	endfunction

	task automatic wait_pulse(input int w);
		int n;
		n = 0;
		while (pick(w) !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 40) begin
				err_total++;
				$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
				give_verdict();
			end
		end
	endtask

	task automatic run_op(input logic [3:0] c, input logic [7:0] b0, b1, b2,
			input int n, input logic [1:0] sel, op, input logic bad,
			input logic [15:0] ea, input logic [7:0] ed);
		cmd_write(c, 1'b1);
		chk1(upper_exec_en, 1'b0);
		sfr_write(A_DAT, b0);
		if (n > 1) sfr_write(A_DAT, b1);
		if (n > 2) sfr_write(A_DAT, b2);
		wait_pulse(0);
		chk8({2'h0, fl_sel, 2'h0, fl_op}, {2'h0, sel, 2'h0, op});
		if (op == fiap_pkg::OP_PROGRAM) chk8(fl_wdata, ed);
		if (n == 3) chk16(fl_addr, ea);
		chk_read(A_CMD, {4'h0, c});
		cmd_write(4'h0, 1'b1);
		chk_read(A_CMD, {4'h0, c});
		@(negedge sys_clk);
		fl_fail = bad;
		fl_done = ~bad;
		@(negedge sys_clk);
		fl_fail = 1'b0;
		fl_done = 1'b0;
		chk_read(A_CMD, {1'b1, bad, 2'h0, c});
		sfr_write(A_DAT, b0);
		chk1(fl_start, 1'b0);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		chk_read(A_CMD, 8'h80);
		chk1(upper_exec_en, 1'b1);
		chk1(wdt_por_en, 1'b0);
		chk_read(A_DAT, 8'h00);
		chk_read(8'h80, 8'h00);
		sfr_write(A_DAT, 8'h12);
		chk1(fl_start, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_verify();
		cmd_write(4'h1, 1'b1);
		repeat (3) @(negedge sys_clk);
		chk_read(A_DAT, 8'hff);
		cmd_write(4'h3, 1'b0);
		chk_read(A_CMD, 8'h81);
		cmd_write(4'h3, 1'b1);
		sfr_write(A_DAT, 8'h21);
		sfr_write(A_DAT, 8'h00);
		wait_pulse(1);
		chk16(fl_addr, 16'h2100);
		chk8({2'h0, fl_sel, 2'h0, fl_op}, 8'h00);
		repeat (3) @(negedge sys_clk);
		chk_read(A_DAT, 8'ha5);
		// An address above the upper bank must never reach the flash.
		cmd_write(4'h3, 1'b1);
		sfr_write(A_DAT, 8'h40);
		sfr_write(A_DAT, 8'h00);
		chk1(fl_rd, 1'b0);
		repeat (2) @(negedge sys_clk);
		chk_read(A_DAT, 8'hff);
		chk_read(A_CMD, 8'hc3);
		cmd_write(4'h2, 1'b1);
		sfr_write(A_DAT, fiap_pkg::LOCK_ADDR);
		wait_pulse(1);
		chk8({6'h00, fl_sel}, 8'h01);
		chk8(fl_addr[7:0], fiap_pkg::LOCK_ADDR);
		repeat (2) @(negedge sys_clk);
		chk_read(A_DAT, 8'ha5);
		$display("test verify done");
	endtask

	task automatic t_program();
		run_op(4'hb, 8'h20, 8'h10, 8'h5a, 3, fiap_pkg::SEL_UPPER,
			fiap_pkg::OP_PROGRAM, 1'b0, 16'h2010, 8'h5a);
		run_op(4'he, 8'h00, 8'h00, 8'h00, 1, fiap_pkg::SEL_UPPER,
			fiap_pkg::OP_ERASE, 1'b0, 16'h0000, 8'h00);
		$display("test program done");
	endtask

	task automatic t_option();
		run_op(4'h9, 8'h08, 8'h00, 8'h00, 1, fiap_pkg::SEL_OPTION,
			fiap_pkg::OP_PROGRAM, 1'b1, 16'h0000, 8'h08);
		chk1(wdt_por_en, 1'b0);
		run_op(4'h9, 8'hf7, 8'h00, 8'h00, 1, fiap_pkg::SEL_OPTION,
			fiap_pkg::OP_PROGRAM, 1'b0, 16'h0000, 8'hf7);
		chk1(wdt_por_en, 1'b1);
		cmd_write(4'h1, 1'b1);
		repeat (3) @(negedge sys_clk);
		chk_read(A_DAT, 8'hf7);
		run_op(4'hc, 8'h00, 8'h00, 8'h00, 1, fiap_pkg::SEL_OPTION,
			fiap_pkg::OP_ERASE, 1'b0, 16'h0000, 8'h00);
		chk1(wdt_por_en, 1'b0);
		$display("test option done");
	endtask

	task automatic t_locks();
		logic [7:0] ids [3];
		logic [7:0] adr [3];
		ids = '{T_MFR, T_PART, T_EXT};
		adr = '{fiap_pkg::SIG_MFR_ADDR, fiap_pkg::SIG_PART_ADDR,
			fiap_pkg::SIG_EXT_ADDR};
		for (int i = 0; i < 3; i++) begin
			ldr_mode_pin = (i != 2);
			par_mode_pin = (i == 2);
			sig_addr = adr[i];
			repeat (4) @(negedge sys_clk);
			chk8(sig_rdata, ids[i]);
		end
		chk1(ldr_verify_ok, 1'b1);
		chk1(ldr_program_ok, 1'b1);
		run_op(4'ha, fiap_pkg::LOCK_ADDR, 8'h00, 8'h00, 2, fiap_pkg::SEL_SEC,
			fiap_pkg::OP_PROGRAM, 1'b0, 16'h0000, 8'h00);
		chk1(ldr_verify_ok, 1'b0);
		chk1(ldr_program_ok, 1'b0);
		run_op(4'hb, 8'h3f, 8'hff, 8'h00, 3, fiap_pkg::SEL_UPPER,
			fiap_pkg::OP_PROGRAM, 1'b0, 16'h3fff, 8'h00);
		run_op(4'hd, 8'h00, 8'h00, 8'h00, 1, fiap_pkg::SEL_SEC,
			fiap_pkg::OP_ERASE, 1'b0, 16'h0000, 8'h00);
		chk1(ldr_verify_ok, 1'b1);
		ldr_mode_pin = 1'b0;
		par_mode_pin = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk8(sig_rdata, 8'h00);
		$display("test locks done");
	endtask

	task automatic t_sysreset();
		cmd_write(4'hf, 1'b1);
		wait_pulse(2);
		repeat (2) @(negedge sys_clk);
		chk_read(A_CMD, 8'h80);
		chk1(upper_exec_en, 1'b1);
		cmd_write(4'h3, 1'b1);
		@(negedge sys_clk);
		rst = 1'b1;
		@(negedge sys_clk);
		rst = 1'b0;
		chk_read(A_CMD, 8'h80);
		$display("test sysreset done");
	endtask

	// ************************************************************
	// Clock and main sequence
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial begin
		err_total = 0;
		cmp_count = 0;
		rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		ta_open = 1'b0;
		fl_rdata = 8'ha5;
		fl_done = 1'b0;
		fl_fail = 1'b0;
		ldr_mode_pin = 1'b0;
		par_mode_pin = 1'b0;
		sig_addr = 8'h00;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_verify();
		t_program();
		t_option();
		t_locks();
		t_sysreset();
		give_verdict();
	end
endmodule
